// ### pkg/pab_params.svh
// pab_params.svh: constants shared by both ends of the agent signalling link
// assumes: included by bare name from the package and the design files
`ifndef PAB_PARAMS_SVH
`define PAB_PARAMS_SVH
`define PAB_AD_W 32
`define PAB_CBE_W 4
`define PAB_FIFO_DEPTH 8
`define PAB_CMD_READ 4'h6
`define PAB_CMD_WRITE 4'h7
`define PAB_CLK_NS 50
`define PAB_CLK_MAX_KHZ 33333
`define PAB_DEVSEL_DLY 1
`endif

// ### pkg/pab_pkg.sv
// pab_pkg.sv: types shared by both ends of the agent signalling link
// assumes: pab_params.svh is on the include path
`include "pab_params.svh"
package pab_pkg;
  typedef enum logic [1:0] {
    PAB_M_IDLE,
    PAB_M_ADDR,
    PAB_M_DATA,
    PAB_M_TURN
  } pab_mst_t;
  typedef enum logic [1:0] {
    PAB_T_IDLE,
    PAB_T_CLAIM,
    PAB_T_DATA,
    PAB_T_TURN
  } pab_tgt_t;
endpackage : pab_pkg

// ### pkg/pab_bus_if.sv
// pab_bus_if.sv: shared bus wires between the device end and the far end
// assumes: every wire is active high here; the interface resolves enables
`timescale 1ns/10ps
`default_nettype none
interface pab_bus_if;
  // each two-way line: driven value and enable from each party
  logic [31:0] devAd, hostAd, ad;
  logic devAdOe, hostAdOe;
  logic [3:0] devCbe, hostCbe, cbe;
  logic devCbeOe, hostCbeOe;
  logic devPar, hostPar, par;
  logic devParOe, hostParOe;
  logic devFrame, hostFrame, frame;
  logic devFrameOe, hostFrameOe;
  logic devIrdy, hostIrdy, irdy;
  logic devIrdyOe, hostIrdyOe;
  logic devTrdy, hostTrdy, trdy;
  logic devTrdyOe, hostTrdyOe;
  logic devDevsel, hostDevsel, devsel;
  logic devDevselOe, hostDevselOe;
  logic devStop, hostStop, stop;
  logic devStopOe, hostStopOe;
  logic devPerr, hostPerr, perr;
  logic devPerrOe, hostPerrOe;
  logic req, gnt, idsel;
  logic serrOe, intaOe;
  // resolved levels: asserted high, idle low when nobody drives
  assign ad = devAdOe ? devAd : (hostAdOe ? hostAd : 32'h0000_0000);
  assign cbe = devCbeOe ? devCbe : (hostCbeOe ? hostCbe : 4'h0);
  assign par = devParOe ? devPar : (hostParOe & hostPar);
  assign frame = (devFrameOe & devFrame) | (hostFrameOe & hostFrame);
  assign irdy = (devIrdyOe & devIrdy) | (hostIrdyOe & hostIrdy);
  assign trdy = (devTrdyOe & devTrdy) | (hostTrdyOe & hostTrdy);
  assign devsel = (devDevselOe & devDevsel) | (hostDevselOe & hostDevsel);
  assign stop = (devStopOe & devStop) | (hostStopOe & hostStop);
  assign perr = (devPerrOe & devPerr) | (hostPerrOe & hostPerr);
  modport dev (
    input ad, cbe, par, frame, irdy, trdy, devsel, stop, perr, gnt, idsel,
    output devAd, devAdOe, devCbe, devCbeOe, devPar, devParOe,
    output devFrame, devFrameOe, devIrdy, devIrdyOe, devTrdy, devTrdyOe,
    output devDevsel, devDevselOe, devStop, devStopOe, devPerr, devPerrOe,
    output req, serrOe, intaOe
  );
  modport host (
    input ad, cbe, par, frame, irdy, trdy, devsel, stop, perr, req,
    input serrOe, intaOe,
    output hostAd, hostAdOe, hostCbe, hostCbeOe, hostPar, hostParOe,
    output hostFrame, hostFrameOe, hostIrdy, hostIrdyOe, hostTrdy,
    output hostTrdyOe, hostDevsel, hostDevselOe, hostStop, hostStopOe,
    output hostPerr, hostPerrOe, gnt, idsel
  );
endinterface : pab_bus_if
`default_nettype wire

// ### logic/pab_fifo.sv
// pab_fifo.sv: small synchronous fifo with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module pab_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, rdPtr_q;
  // full when pointers differ only in the wrap bit
  assign inReady = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];
  // storage carries no reset so it maps onto plain ram
  always_ff @(posedge mclk) begin
    if (inValid && inReady) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  // pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) wrPtr_q <= wrPtr_q + 1'b1;
      if (outValid && outReady) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule : pab_fifo
`default_nettype wire

// ### logic/pab_dev_agent.sv
// pab_dev_agent.sv: device end of the agent signalling (master and target)
// assumes: bus lines arrive on mclk from logic on the same clock
// How it works
// - parity is even over data, command and parity
// - address parity comes the clock after address
// - data parity one clock after ready handshake
// - parity follows data lines one clock late
// - target drives read parity, master the rest
// - only current master drives and holds frame
// - frame released means final data phase
// - phase completes only with both readies
// - initiator ready once data placed or accepted
// - target ready once data presented or accepted
// - claim select only after decoding own address
// - target stop ends the master's transaction
// - detected data parity error raises perr
// - address parity error pulls system error low
// - interrupt pulls low while requested, else floats
// - every bus line sampled on rising clock
// - reset floats every bus output at once
// - address phase is first frame clock
`timescale 1ns/10ps
`default_nettype none
`include "pab_params.svh"
module pab_dev_agent #(
  parameter int DEPTH = `PAB_FIFO_DEPTH,
  parameter logic [31:0] BASE = 32'h1000_0000,
  parameter logic [31:0] MASK = 32'hFFFF_F000
) (
  input wire logic mclk,
  input wire logic rst_n,
  pab_bus_if.dev bus,
  input wire logic mstStart,
  input wire logic mstWrite,
  input wire logic [31:0] mstAddr,
  input wire logic [3:0] mstBe,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [31:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [31:0] rdData,
  output logic mstBusy,
  output logic mstStopped,
  input wire logic [31:0] tgtRdData,
  output logic [31:0] tgtWrData,
  output logic tgtWrStb,
  input wire logic intReq,
  output logic parErr,
  output logic addrParErr
);
  if (DEPTH < 2) begin : g_bad_depth
    $error("fifo depth too small");
  end
  // even parity of 36 lines, used for both drive and check
  function automatic logic evenPar(input logic [31:0] a, input logic [3:0] c);
    evenPar = ^{a, c};
  endfunction : evenPar

  typedef struct packed {
    pab_pkg::pab_mst_t ms;
    pab_pkg::pab_tgt_t ts;
    logic [31:0] adOut;
    logic [3:0] cbeOut;
    logic adOe;
    logic cbeOe;
    logic parOut;
    logic parOe;
    logic frameOut;
    logic irdyOut;
    logic mCtlOe;
    logic trdyOut;
    logic devselOut;
    logic stopOut;
    logic tCtlOe;
    logic tWrite;
    logic req;
    logic [31:0] addr;
    logic [31:0] adPrev;
    logic [3:0] cbePrev;
    logic chkAddr;
    logic chkData;
    logic perrOut;
    logic perrOe;
    logic serr;
    logic stopped;
    logic [31:0] tWrData;
    logic tWrStb;
  } pab_dev_st_t;
  pab_dev_st_t s_q, s_d;

  // --------------------------------------------------------------
  // read and write data buffers: the user side can stall the read one until it fills
  // --------------------------------------------------------------
  logic rdPush, rdRoom, wrPop, wrHave;
  logic [31:0] wrHead;
  pab_fifo #(.WIDTH(32), .DEPTH(DEPTH)) uRdFifo (
    .mclk(mclk), .rst_n(rst_n), .inValid(rdPush), .inReady(rdRoom),
    .inData(bus.ad), .outValid(rdValid), .outReady(rdReady),
    .outData(rdData)
  );
  pab_fifo #(.WIDTH(32), .DEPTH(DEPTH)) uWrFifo (
    .mclk(mclk), .rst_n(rst_n), .inValid(wrValid), .inReady(wrReady),
    .inData(wrData), .outValid(wrHave), .outReady(wrPop),
    .outData(wrHead)
  );

  logic xfer;
  assign xfer = bus.irdy && bus.trdy;
  assign rdPush = s_q.ms == pab_pkg::PAB_M_DATA && !s_q.tWrite && xfer;
  // pop as a word goes onto the lines, so the head is already the next
  // word when the phase completes and no word is sent twice
  assign wrPop = s_q.tWrite && wrHave && (s_q.ms == pab_pkg::PAB_M_ADDR
    || (s_q.ms == pab_pkg::PAB_M_DATA
    && ((xfer && s_q.frameOut) || !s_q.irdyOut)));

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic hit;
    logic last;
    hit = 1'b0;
    last = 1'b0;
    s_d = s_q;
    s_d.tWrStb = 1'b0;
    s_d.perrOut = 1'b0;
    s_d.perrOe = 1'b0;
    s_d.serr = 1'b0;
    // parity of what was on the lines one clock ago
    s_d.adPrev = bus.ad;
    s_d.cbePrev = bus.cbe;
    s_d.parOut = evenPar(s_q.adOut, bus.cbe);
    s_d.parOe = s_q.adOe;
    s_d.chkAddr = bus.frame && !s_q.frameOut && s_q.ms == pab_pkg::PAB_M_IDLE
      && s_q.ts == pab_pkg::PAB_T_IDLE && !s_q.chkAddr && !s_q.tCtlOe;
    s_d.chkData = xfer && !s_q.adOe;
    // check parity received from the other party
    if (s_q.chkAddr && evenPar(s_q.adPrev, s_q.cbePrev) != bus.par) begin
      s_d.serr = 1'b1;
    end
    if (s_q.chkData && evenPar(s_q.adPrev, s_q.cbePrev) != bus.par) begin
      s_d.perrOut = 1'b1;
      s_d.perrOe = 1'b1;
    end
    // master side
    unique case (s_q.ms)
      pab_pkg::PAB_M_IDLE: begin
        s_d.req = mstStart;
        if (mstStart && bus.gnt && !bus.frame && !bus.irdy
            && s_q.ts == pab_pkg::PAB_T_IDLE) begin
          s_d.ms = pab_pkg::PAB_M_ADDR;
          s_d.tWrite = mstWrite;
          s_d.adOut = mstAddr;
          s_d.cbeOut = mstWrite ? `PAB_CMD_WRITE : `PAB_CMD_READ;
          s_d.adOe = 1'b1;
          s_d.cbeOe = 1'b1;
          s_d.frameOut = 1'b1;
          s_d.mCtlOe = 1'b1;
          s_d.stopped = 1'b0;
        end
      end
      pab_pkg::PAB_M_ADDR: begin
        s_d.ms = pab_pkg::PAB_M_DATA;
        s_d.cbeOut = mstBe;
        s_d.adOe = s_q.tWrite;
        if (s_q.tWrite) s_d.adOut = wrHead;
        s_d.irdyOut = s_q.tWrite ? wrHave : rdRoom;
        s_d.frameOut = !(s_q.tWrite ? !wrHave : 1'b0) || mstStart;
      end
      pab_pkg::PAB_M_DATA: begin
        last = !s_q.frameOut;
        if (bus.stop || (xfer && last)) begin
          s_d.ms = pab_pkg::PAB_M_TURN;
          s_d.frameOut = 1'b0;
          s_d.irdyOut = 1'b0;
          s_d.adOe = 1'b0;
          s_d.stopped = bus.stop;
        end else begin
          if (wrPop) s_d.adOut = wrHead;
          // keep framing while the user still wants more data
          s_d.frameOut = mstStart && !last;
          s_d.irdyOut = s_q.tWrite ? wrPop || (s_q.irdyOut && !xfer)
            : rdRoom;
        end
      end
      pab_pkg::PAB_M_TURN: begin
        s_d.ms = pab_pkg::PAB_M_IDLE;
        s_d.mCtlOe = 1'b0;
        s_d.cbeOe = 1'b0;
      end
      default: s_d.ms = pab_pkg::PAB_M_IDLE;
    endcase
    // target side: claim only our own window
    hit = (bus.ad & MASK) == BASE;
    unique case (s_q.ts)
      pab_pkg::PAB_T_IDLE: begin
        if (s_d.chkAddr && hit && (bus.cbe == `PAB_CMD_READ
            || bus.cbe == `PAB_CMD_WRITE)) begin
          s_d.ts = pab_pkg::PAB_T_CLAIM;
          s_d.tWrite = bus.cbe == `PAB_CMD_WRITE;
          s_d.addr = bus.ad;
        end
      end
      pab_pkg::PAB_T_CLAIM: begin
        s_d.ts = pab_pkg::PAB_T_DATA;
        s_d.devselOut = 1'b1;
        s_d.tCtlOe = 1'b1;
        s_d.trdyOut = 1'b1;
        s_d.adOe = !s_q.tWrite;
        s_d.adOut = tgtRdData;
        // single-word target: stop asks the master to end
        s_d.stopOut = bus.frame;
      end
      pab_pkg::PAB_T_DATA: begin
        if (xfer) begin
          s_d.ts = pab_pkg::PAB_T_TURN;
          s_d.tWrite = 1'b0;
          s_d.trdyOut = 1'b0;
          s_d.devselOut = 1'b0;
          s_d.stopOut = 1'b0;
          s_d.adOe = 1'b0;
          s_d.tWrStb = s_q.tWrite;
          s_d.tWrData = bus.ad;
        end
      end
      pab_pkg::PAB_T_TURN: begin
        s_d.ts = pab_pkg::PAB_T_IDLE;
        s_d.tCtlOe = 1'b0;
      end
      default: s_d.ts = pab_pkg::PAB_T_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // state register; reset floats every bus output
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end

  // bus drive
  assign bus.devAd = s_q.adOut;
  assign bus.devAdOe = s_q.adOe;
  assign bus.devCbe = s_q.cbeOut;
  assign bus.devCbeOe = s_q.cbeOe;
  assign bus.devPar = s_q.parOut;
  assign bus.devParOe = s_q.parOe;
  assign bus.devFrame = s_q.frameOut;
  assign bus.devFrameOe = s_q.mCtlOe;
  assign bus.devIrdy = s_q.irdyOut;
  assign bus.devIrdyOe = s_q.mCtlOe;
  assign bus.devTrdy = s_q.trdyOut;
  assign bus.devTrdyOe = s_q.tCtlOe;
  assign bus.devDevsel = s_q.devselOut;
  assign bus.devDevselOe = s_q.tCtlOe;
  assign bus.devStop = s_q.stopOut;
  assign bus.devStopOe = s_q.tCtlOe;
  assign bus.devPerr = s_q.perrOut;
  assign bus.devPerrOe = s_q.perrOe;
  assign bus.req = s_q.req;
  assign bus.serrOe = s_q.serr;
  // interrupt is a pure open-drain pull, no clocked state
  assign bus.intaOe = intReq && rst_n;
  assign mstBusy = s_q.ms != pab_pkg::PAB_M_IDLE;
  assign mstStopped = s_q.stopped;
  assign tgtWrData = s_q.tWrData;
  assign tgtWrStb = s_q.tWrStb;
  assign parErr = s_q.perrOut;
  assign addrParErr = s_q.serr;
endmodule : pab_dev_agent
`default_nettype wire

// ### logic/pab_host_agent.sv
// pab_host_agent.sv: far end: arbiter plus a simple master and target
// assumes: one peer device on the bus, same clock
`timescale 1ns/10ps
`default_nettype none
`include "pab_params.svh"
module pab_host_agent (
  input wire logic mclk,
  input wire logic rst_n,
  pab_bus_if.host bus,
  input wire logic hStart,
  input wire logic hWrite,
  input wire logic [31:0] hAddr,
  input wire logic [31:0] hWrData,
  output logic [31:0] hRdData,
  output logic hDone,
  input wire logic [31:0] memRdData,
  output logic hParErr,
  output logic devIrq,
  output logic devSysErr
);
  function automatic logic evenPar(input logic [31:0] a, input logic [3:0] c);
    evenPar = ^{a, c};
  endfunction : evenPar
  typedef struct packed {
    pab_pkg::pab_mst_t ms;
    pab_pkg::pab_tgt_t ts;
    logic gnt;
    logic write;
    logic [31:0] adOut;
    logic [3:0] cbeOut;
    logic adOe, cbeOe, parOut, parOe;
    logic frameOut, irdyOut, mOe;
    logic trdyOut, devselOut, tOe;
    logic [31:0] adPrev;
    logic [3:0] cbePrev;
    logic chk, perr;
    logic [31:0] rd;
    logic done;
  } pab_host_st_t;
  pab_host_st_t s_q, s_d;
  logic xfer;
  assign xfer = bus.irdy && bus.trdy;
  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.perr = 1'b0;
    s_d.adPrev = bus.ad;
    s_d.cbePrev = bus.cbe;
    s_d.parOut = evenPar(s_q.adOut, bus.cbe); // one clock late
    s_d.parOe = s_q.adOe;
    s_d.chk = xfer && !s_q.adOe;
    if (s_q.chk && evenPar(s_q.adPrev, s_q.cbePrev) != bus.par) begin
      s_d.perr = 1'b1;
    end
    // grant the device only while host master is idle
    s_d.gnt = bus.req && s_q.ms == pab_pkg::PAB_M_IDLE && !hStart;
    unique case (s_q.ms)
      pab_pkg::PAB_M_IDLE: if (hStart && !s_q.gnt && !bus.frame) begin
        s_d.ms = pab_pkg::PAB_M_ADDR;
        s_d.write = hWrite;
        s_d.adOut = hAddr;
        s_d.cbeOut = hWrite ? `PAB_CMD_WRITE : `PAB_CMD_READ;
        s_d.adOe = 1'b1;
        s_d.cbeOe = 1'b1;
        s_d.frameOut = 1'b1;
        s_d.mOe = 1'b1;
      end
      pab_pkg::PAB_M_ADDR: begin
        s_d.ms = pab_pkg::PAB_M_DATA;
        s_d.frameOut = 1'b0; // single data phase
        s_d.irdyOut = 1'b1;
        s_d.cbeOut = 4'h0;
        s_d.adOe = s_q.write;
        s_d.adOut = hWrData;
      end
      pab_pkg::PAB_M_DATA: if (xfer || bus.stop) begin
        s_d.ms = pab_pkg::PAB_M_TURN;
        s_d.irdyOut = 1'b0;
        s_d.adOe = 1'b0;
        s_d.rd = bus.ad;
        s_d.done = 1'b1;
      end
      pab_pkg::PAB_M_TURN: begin
        s_d.ms = pab_pkg::PAB_M_IDLE;
        s_d.mOe = 1'b0;
        s_d.cbeOe = 1'b0;
      end
      default: s_d.ms = pab_pkg::PAB_M_IDLE;
    endcase
    // memory target: claims every device access
    unique case (s_q.ts)
      pab_pkg::PAB_T_IDLE: if (bus.frame && s_q.gnt) begin
        s_d.ts = pab_pkg::PAB_T_CLAIM;
        s_d.write = bus.cbe == `PAB_CMD_WRITE;
      end
      pab_pkg::PAB_T_CLAIM: begin
        s_d.ts = pab_pkg::PAB_T_DATA;
        s_d.devselOut = 1'b1;
        s_d.trdyOut = 1'b1;
        s_d.tOe = 1'b1;
        s_d.adOe = !s_q.write;
        s_d.adOut = memRdData;
      end
      pab_pkg::PAB_T_DATA: if (xfer && !bus.frame) begin
        s_d.ts = pab_pkg::PAB_T_TURN;
        s_d.trdyOut = 1'b0;
        s_d.devselOut = 1'b0;
        s_d.adOe = 1'b0;
      end else if (xfer) begin
        s_d.adOut = memRdData;
      end
      pab_pkg::PAB_T_TURN: begin
        s_d.ts = pab_pkg::PAB_T_IDLE;
        s_d.tOe = 1'b0;
      end
      default: s_d.ts = pab_pkg::PAB_T_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end
  // bus drive
  assign bus.hostAd = s_q.adOut;
  assign bus.hostAdOe = s_q.adOe;
  assign bus.hostCbe = s_q.cbeOut;
  assign bus.hostCbeOe = s_q.cbeOe;
  assign bus.hostPar = s_q.parOut;
  assign bus.hostParOe = s_q.parOe;
  assign bus.hostFrame = s_q.frameOut;
  assign bus.hostFrameOe = s_q.mOe;
  assign bus.hostIrdy = s_q.irdyOut;
  assign bus.hostIrdyOe = s_q.mOe;
  assign bus.hostTrdy = s_q.trdyOut;
  assign bus.hostTrdyOe = s_q.tOe;
  assign bus.hostDevsel = s_q.devselOut;
  assign bus.hostDevselOe = s_q.tOe;
  assign bus.hostStop = 1'b0;
  assign bus.hostStopOe = s_q.tOe;
  assign bus.hostPerr = s_q.perr;
  assign bus.hostPerrOe = s_q.perr;
  assign bus.gnt = s_q.gnt;
  assign bus.idsel = 1'b0;
  assign hRdData = s_q.rd;
  assign hDone = s_q.done;
  assign hParErr = s_q.perr;
  assign devIrq = bus.intaOe;
  assign devSysErr = bus.serrOe;
endmodule : pab_host_agent
`default_nettype wire

// ### bench/pab_bus_assertions.sv
// pab_bus_assertions.sv: checker on the shared bus lines of the link
// assumes: instantiated in tb_top beside the interface, one clock domain
`timescale 1ns/10ps
`default_nettype none
module pab_bus_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame,
  input wire logic irdy,
  input wire logic trdy,
  input wire logic devsel,
  input wire logic stop,
  input wire logic devAdOe,
  input wire logic hostAdOe,
  input wire logic devParOe,
  input wire logic hostParOe,
  input wire logic devFrameOe,
  input wire logic hostFrameOe,
  input wire logic serrOe,
  input wire logic intaOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // parity and ownership
  // ----------------------------------------------------------------
  // parity lags the lines it covers by one clock
  a_par_even: assert property ((devParOe || hostParOe) |->
    ^{par, $past(ad), $past(cbe)} == 1'b0) else $error("parity odd");
  // whoever drove the lines one clock back owns the parity now
  a_par_owner: assert property ((devParOe == $past(devAdOe)) &&
    (hostParOe == $past(hostAdOe))) else $error("parity owner wrong");
  a_one_master: assert property (!(devFrameOe && hostFrameOe))
    else $error("two frame drivers");
  // ----------------------------------------------------------------
  // handshake and framing
  // ----------------------------------------------------------------
  a_wait_hold: assert property (irdy && !trdy && !stop |=> irdy)
    else $error("initiator ready dropped in wait");
  a_last_phase: assert property (!frame && irdy && trdy |=> !irdy)
    else $error("data phase after final one");
  a_claim_sel: assert property ($rose(devsel) |->
    $past(frame) || $past(frame, 2)) else $error("select without access");
  a_stop_end: assert property (stop |-> ##[0:2] !frame)
    else $error("stop not honoured");
  // reset must float the bus even while it is held, so no disable here
  a_reset_float: assert property (disable iff (1'b0) !rst_n |->
    !(devAdOe || hostAdOe || devParOe || devFrameOe || hostFrameOe ||
    serrOe || intaOe)) else $error("bus driven in reset");
  c_dev_write: cover property (frame && irdy && trdy && devAdOe);
  c_stop: cover property (stop && trdy);
  c_irq: cover property (intaOe);
endmodule : pab_bus_assertions
`default_nettype wire

// ### bench/tb_top.sv
// tb_top.sv: both agents face each other; bench drives their user sides
// assumes: design sources and package files compiled before this file
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [31:0] DEV_BASE = 32'h1000_0000;
  localparam logic [31:0] MEM_WORD = 32'hA5C3_0F1E;
  localparam logic [31:0] TGT_WORD = 32'h3C5A_96E1;
  localparam logic [31:0] FAR_ADDR = 32'h2000_0040;
  logic mclk = 1'b0, rst_n = 1'b1;
  logic mstStart = 1'b0, mstWrite = 1'b0, wrValid = 1'b0, rdReady = 1'b0;
  logic hStart = 1'b0, hWrite = 1'b0, intReq = 1'b0;
  logic [3:0] mstBe = 4'hF;
  logic [31:0] mstAddr = 32'h0000_0000, wrData = 32'h0000_0000;
  logic [31:0] hAddr = 32'h0000_0000, hWrData = 32'h0000_0000;
  logic wrReady, rdValid, mstBusy, mstStopped, tgtWrStb, hDone, devIrq;
  logic parErr, addrParErr, hParErr, devSysErr;
  logic [31:0] rdData, tgtWrData, hRdData, lastTgt;
  logic [31:0] seenQ[$];
  int xferCnt = 0, errCnt = 0, failures = 0, nCompared = 0;
  always #25 mclk = ~mclk;
  pab_bus_if pab_bus_if_inst ();
  pab_dev_agent pab_dev_agent_inst (.mclk(mclk), .rst_n(rst_n),
    .bus(pab_bus_if_inst.dev), .mstStart(mstStart), .mstWrite(mstWrite),
    .mstAddr(mstAddr), .mstBe(mstBe), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
    .mstBusy(mstBusy), .mstStopped(mstStopped), .tgtRdData(TGT_WORD),
    .tgtWrData(tgtWrData), .tgtWrStb(tgtWrStb), .intReq(intReq),
    .parErr(parErr), .addrParErr(addrParErr));
  pab_host_agent pab_host_agent_inst (.mclk(mclk), .rst_n(rst_n),
    .bus(pab_bus_if_inst.host), .hStart(hStart), .hWrite(hWrite),
    .hAddr(hAddr), .hWrData(hWrData), .hRdData(hRdData), .hDone(hDone),
    .memRdData(MEM_WORD), .hParErr(hParErr), .devIrq(devIrq),
    .devSysErr(devSysErr));
  pab_bus_assertions pab_bus_assertions_inst (.mclk(mclk), .rst_n(rst_n),
    .ad(pab_bus_if_inst.ad), .cbe(pab_bus_if_inst.cbe),
    .par(pab_bus_if_inst.par), .frame(pab_bus_if_inst.frame),
    .irdy(pab_bus_if_inst.irdy), .trdy(pab_bus_if_inst.trdy),
    .devsel(pab_bus_if_inst.devsel), .stop(pab_bus_if_inst.stop),
    .devAdOe(pab_bus_if_inst.devAdOe), .hostAdOe(pab_bus_if_inst.hostAdOe),
    .devParOe(pab_bus_if_inst.devParOe),
    .hostParOe(pab_bus_if_inst.hostParOe),
    .devFrameOe(pab_bus_if_inst.devFrameOe),
    .hostFrameOe(pab_bus_if_inst.hostFrameOe),
    .serrOe(pab_bus_if_inst.serrOe), .intaOe(pab_bus_if_inst.intaOe));
  // ----------------------------------------------------------------
  // bus monitor: completed phases, target writes, error pulses
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (pab_bus_if_inst.irdy && pab_bus_if_inst.trdy) begin
      xferCnt <= xferCnt + 1;
      if (pab_bus_if_inst.devAdOe) seenQ.push_back(pab_bus_if_inst.ad);
    end
    if (tgtWrStb) lastTgt <= tgtWrData;
    if (parErr || hParErr || addrParErr || devSysErr) errCnt <= errCnt + 1;
  end
  // ----------------------------------------------------------------
  // compare, verdict and access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (failures == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic hang();
    failures++;
    summarize();
  endtask : hang
  // one word into the write fifo; ready must stand before the edge
  task automatic push(input logic [31:0] d);
    @(negedge mclk);
    wrValid = 1'b1;
    wrData = d;
    check({31'd0, wrReady}, 32'd1);
    @(negedge mclk);
    wrValid = 1'b0;
  endtask : push
  // burst of n phases; frame falls on the clock that sees the request
  // low, so it is dropped once n-2 back-to-back phases are done
  task automatic mst_run(input logic wr, input logic [31:0] a, input int n);
    int i;
    @(negedge mclk);
    xferCnt = 0;
    seenQ.delete();
    mstWrite = wr;
    mstAddr = a;
    mstStart = 1'b1;
    for (i = 0; i < 400 && !(mstBusy && xferCnt >= n - 2); i++)
      @(negedge mclk);
    mstStart = 1'b0;
    for (i = 0; i < 400 && (mstBusy !== 1'b0); i++) @(negedge mclk);
    if (i == 400) hang();
    check(xferCnt, n);
    check({31'd0, mstStopped}, 32'd0);
  endtask : mst_run
  task automatic host_op(input logic wr, input logic [31:0] a, d);
    int i;
    @(negedge mclk);
    hStart = 1'b1;
    hWrite = wr;
    hAddr = a;
    hWrData = d;
    for (i = 0; i < 200 && hDone !== 1'b1; i++) @(negedge mclk);
    hStart = 1'b0;
    if (hDone !== 1'b1) hang();
  endtask : host_op
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    // a real falling step, so the async reset acts before the first edge
    #1;
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    push(32'hC001_0001);
    mst_run(1'b1, FAR_ADDR, 1);
    check(seenQ.size() > 0 ? seenQ[0] : 32'hXXXX_XXXX, 32'hC001_0001);
    // fill the write fifo until it refuses, then burst it out
    for (k = 0; k < 8; k++) push(32'h5A00_0000 + k);
    @(negedge mclk);
    check({31'd0, wrReady}, 32'd0);
    mst_run(1'b1, FAR_ADDR, 8);
    for (k = 0; k < 8 && k < seenQ.size(); k++)
      check(seenQ[k], 32'h5A00_0000 + k);
    check({31'd0, wrReady}, 32'd1);
    // read burst with the consumer stalled, then drain to empty
    mst_run(1'b0, FAR_ADDR, 8);
    for (k = 0; k < 8; k++) begin
      @(negedge mclk);
      check({31'd0, rdValid}, 32'd1);
      check(rdData, MEM_WORD);
      rdReady = 1'b1;
      @(negedge mclk);
      rdReady = 1'b0;
    end
    check({31'd0, rdValid}, 32'd0);
    // far end writes then reads the device target back to back
    host_op(1'b1, DEV_BASE + 32'h0000_0004, 32'h0BAD_F00D);
    repeat (2) @(negedge mclk);
    check(lastTgt, 32'h0BAD_F00D);
    host_op(1'b0, DEV_BASE + 32'h0000_0008, 32'h0000_0000);
    check(hRdData, TGT_WORD);
    // interrupt pulls while requested and floats afterwards
    intReq = 1'b1;
    repeat (3) @(negedge mclk);
    check({31'd0, devIrq}, 32'd1);
    // reset in mid-run floats the interrupt at once, clock or not
    rst_n = 1'b0;
    #1;
    check({31'd0, pab_bus_if_inst.intaOe}, 32'd0);
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    intReq = 1'b0;
    repeat (3) @(negedge mclk);
    check({31'd0, devIrq}, 32'd0);
    check(errCnt, 0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
